// [inc/pic_defines.vh]
// Constants for the eight-level priority interrupt controller.
// Included by every design file; holds definitions only.
`ifndef PIC_DEFINES_VH
`define PIC_DEFINES_VH

// Register indices; byte address is four times the index
`define PIC_IDX_EVEN      2'h0
`define PIC_IDX_ODD       2'h1
`define PIC_IDX_ACK       2'h2

// First setup word fields
`define PIC_W1_SEL_BIT    4
`define PIC_W1_TRIG_BIT   3
`define PIC_W1_SINGLE_BIT 1
`define PIC_W1_W4_BIT     0

// Fourth setup word fields
`define PIC_W4_SPECIAL_NESTING_SELECT_BIT   4
`define PIC_W4_AUTO_END_OF_INTERRUPT_BIT   1

// Operation word selectors, data bits 4:3
`define PIC_SEL_EOI_ROT   2'h0
`define PIC_SEL_POLL_RD   2'h1

// Third operation word fields
`define PIC_W3_ESMM_BIT   6
`define PIC_W3_SMM_BIT    5
`define PIC_W3_POLL_BIT   2
`define PIC_W3_RR_BIT     1
`define PIC_W3_RS_BIT     0

// Second operation word commands, data bits 7:5
`define PIC_CMD_NS_EOI    3'h1
`define PIC_CMD_SP_EOI    3'h3
`define PIC_CMD_ROT_NS    3'h5
`define PIC_CMD_AROT_SET  3'h4
`define PIC_CMD_AROT_CLR  3'h0
`define PIC_CMD_ROT_SP    3'h7
`define PIC_CMD_SET_PRI   3'h6
`define PIC_CMD_NOP       3'h2

// Reset values
`define PIC_RST_LOWPRI    3'h7
`define PIC_RST_MASK      8'h00
`define PIC_SPURIOUS_LVL  3'h7

`endif

// [src/pic_prio_pick.v]
// Picks the highest-priority set bit of an eight-level vector.
// Assumes lowPri names the lowest level; the next level up is highest.
`timescale 1ns/100ps
`include "pic_defines.vh"

module pic_prio_pick (
  input  wire [7:0] reqVec,
  input  wire [2:0] lowPri,
  output reg        anySet,
  output reg  [2:0] level
);

  integer i;
  reg     [2:0] idx;

  // Scan upward from the level after the lowest, wrapping 7 to 0
  always @* begin
    anySet = 1'b0;
    level  = 3'h0;
    idx    = 3'h0;
    for (i = 0; i < 8; i = i + 1) begin
      idx = lowPri + 3'h1 + i[2:0];
      if (!anySet && reqVec[idx]) begin
        anySet = 1'b1;
        level  = idx;
      end
    end
  end

endmodule

// [src/pic_ctrl.v]
// Eight-level programmable priority interrupt controller core.
// Assumes an Avalon-MM master on core_clk and request inputs
// synchronous to core_clk; ackStrobe pulses once per acknowledge cycle.
//
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "pic_defines.vh"

//Behaviour
//- Specific EOI clears the addressed level
//- Non-specific EOI clears highest in-service level
//- Auto EOI after final acknowledge cycle
//- Auto EOI works as master or slave
//- Fully nested unless special nesting chosen
//- Acknowledge returns vector, sets in-service bit
//- In service blocks same and lower levels
//- Special nesting lets slave level re-enter
//- Special mask blocks only masked levels
//- Special mask: non-specific EOI skips masked
//- Named lowest level, others rank upward
//- Level 7 lowest after setup; changeable
//- Set priority or rotate-specific rotates
//- With auto EOI, auto rotation makes serviced level lowest
//- Poll read: active flag, zeros, level
//- Read after poll is always poll read
//- Odd read returns the mask register
//- Even read gives in-service or request
//- Edge mode latches rising edges only
//- Level mode asserts while input high
//- Short request answers as level 7
//- Decode second operation word commands
//- Bits 4:3 select second or third word
//- No data first cycle, vector second
module pic_ctrl (
  input  wire        core_clk,
  input  wire        srst,
  input  wire [1:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire [7:0]  irqIn,
  input  wire        ackStrobe,
  output wire        intReq,
  output wire [7:0]  vecData,
  output wire        vecValid
);

  localparam [3:0] ST_READY = 4'h1;
  localparam [3:0] ST_W2    = 4'h2;
  localparam [3:0] ST_W3    = 4'h4;
  localparam [3:0] ST_W4    = 4'h8;

  reg  [7:0] irr_q;
  reg  [7:0] isr_q;
  reg  [7:0] imr_q;
  reg  [7:0] irqPrev_q;
  reg  [7:0] slaveMap_q;
  reg  [4:0] vecBase_q;
  reg  [2:0] lowPri_q;
  reg        trigLevel_q;
  reg        single_q;
  reg        needW4_q;
  reg        auto_end_of_interrupt_q;
  reg        special_nesting_select_q;
  reg        smm_q;
  reg        autoRot_q;
  reg        readIsr_q;
  reg        poll_q;
  reg  [3:0] initSt_q;
  reg        ackPhase_q;
  reg  [2:0] ackLevel_q;
  reg  [7:0] vecData_q;
  reg        vecValid_q;
  reg        intReq_q;
  reg        busAck_q;
  reg  [7:0] rdData_q;
  reg        pollHit_q;
  reg  [2:0] pollLvl_q;

  reg  [7:0] irr_d;
  reg  [7:0] isr_d;
  reg  [7:0] isrClr;
  reg  [7:0] isrSet;
  reg  [7:0] irrClr;
  reg  [2:0] lowPri_d;
  reg  [7:0] rdData_d;

  wire [7:0] req;
  wire [7:0] isrEff;
  wire       reqAny;
  wire [2:0] reqLvl;
  wire       isrAny;
  wire [2:0] isrLvl;
  wire       reqWins;
  wire       busReq;
  wire       wrEn;
  wire       rdEn;
  wire [7:0] wd;
  wire       evenWr;
  wire       setup1;
  wire       opWord2;
  wire       opWord3;
  wire       oddWr;
  wire       ready;
  wire [7:0] rise;
  wire [7:0] irrSet;
  wire       ack1;
  wire       ack2;
  wire       pollRd;

  // Rank of a level: 0 is highest, 7 is the named lowest
  function [2:0] rankOf;
    input [2:0] lvl;
    input [2:0] low;
    begin
      rankOf = lvl - low - 3'h1;
    end
  endfunction

  function [7:0] oneHot;
    input [2:0] lvl;
    begin
      oneHot = 8'h01 << lvl;
    end
  endfunction

  assign req    = irr_q & ~imr_q;
  // Under special mask, masked in-service levels neither block nor take a plain EOI
  assign isrEff = smm_q ? (isr_q & ~imr_q) : isr_q;

  pic_prio_pick reqPick (
    .reqVec (req),
    .lowPri (lowPri_q),
    .anySet (reqAny),
    .level  (reqLvl)
  );

  pic_prio_pick isrPick (
    .reqVec (isrEff),
    .lowPri (lowPri_q),
    .anySet (isrAny),
    .level  (isrLvl)
  );

  // Only a strictly higher level interrupts, except a slave level
  // under special nesting, which may nest on itself
  assign reqWins = reqAny & (~isrAny
                 | (rankOf(reqLvl, lowPri_q) < rankOf(isrLvl, lowPri_q))
                 | (special_nesting_select_q & (reqLvl == isrLvl)
                    & slaveMap_q[reqLvl]));

  // Bus slave: one wait cycle, then accept
  assign busReq          = avs_read | avs_write;
  assign avs_waitrequest = busReq & ~busAck_q;
  assign avs_readdata    = {24'h000000, rdData_q};
  assign wrEn  = avs_write & busAck_q & avs_byteenable[0];
  assign rdEn  = avs_read & busAck_q;
  assign wd    = avs_writedata[7:0];
  assign ready = initSt_q[0];

  assign evenWr  = wrEn & (avs_address == `PIC_IDX_EVEN);
  assign oddWr   = wrEn & (avs_address == `PIC_IDX_ODD);
  assign setup1  = evenWr & wd[`PIC_W1_SEL_BIT];
  assign opWord2 = evenWr & ready & ~wd[`PIC_W1_SEL_BIT]
                 & (wd[4:3] == `PIC_SEL_EOI_ROT);
  assign opWord3 = evenWr & ready & ~wd[`PIC_W1_SEL_BIT]
                 & (wd[4:3] == `PIC_SEL_POLL_RD);
  assign pollRd  = rdEn & poll_q;

  assign ack1 = ackStrobe & ~ackPhase_q;
  assign ack2 = ackStrobe & ackPhase_q;

  // A request that drops before it is serviced is forgotten
  assign rise   = irqIn & ~irqPrev_q;
  assign irrSet = trigLevel_q ? irqIn : rise;

  assign intReq   = intReq_q;
  assign vecData  = vecData_q;
  assign vecValid = vecValid_q;

  // Read data is prepared in the wait cycle, stable at accept
  always @* begin
    rdData_d = 8'h00;
    if (poll_q)
      rdData_d = {reqWins, 4'h0, reqLvl};
    else if (avs_address == `PIC_IDX_ODD)
      rdData_d = imr_q;
    else if (avs_address == `PIC_IDX_EVEN)
      rdData_d = readIsr_q ? isr_q : irr_q;
  end

  // In-service, request and priority updates from all sources
  always @* begin
    isrClr   = 8'h00;
    isrSet   = 8'h00;
    irrClr   = 8'h00;
    lowPri_d = lowPri_q;
    if (opWord2) begin
      case (wd[7:5])
        `PIC_CMD_NS_EOI: begin
          if (isrAny)
            isrClr = oneHot(isrLvl);
        end
        `PIC_CMD_ROT_NS: begin
          if (isrAny) begin
            isrClr   = oneHot(isrLvl);
            lowPri_d = isrLvl;
          end
        end
        `PIC_CMD_SP_EOI: begin
          isrClr = oneHot(wd[2:0]);
        end
        `PIC_CMD_ROT_SP: begin
          isrClr   = oneHot(wd[2:0]);
          lowPri_d = wd[2:0];
        end
        `PIC_CMD_SET_PRI: begin
          lowPri_d = wd[2:0];
        end
        default: begin
        end
      endcase
    end
    // Auto EOI at the end of the vector cycle, master or slave
    if (ack2 && auto_end_of_interrupt_q && isrAny) begin
      isrClr = isrClr | oneHot(isrLvl);
      if (autoRot_q)
        lowPri_d = isrLvl;
    end
    // A spurious acknowledge sets nothing in service
    if (ack1 && reqWins) begin
      isrSet = oneHot(reqLvl);
      irrClr = oneHot(reqLvl);
    end
    if (pollRd && pollHit_q) begin
      isrSet = isrSet | oneHot(pollLvl_q);
      irrClr = irrClr | oneHot(pollLvl_q);
    end
    // Setting wins over a clear landing in the same cycle
    isr_d = (isr_q & ~isrClr) | isrSet;
    irr_d = (irr_q & irqIn & ~irrClr) | irrSet;
  end

  always @(posedge core_clk) begin
    if (srst) begin
      busAck_q  <= 1'b0;
      rdData_q  <= 8'h00;
      pollHit_q <= 1'b0;
      pollLvl_q <= 3'h0;
      irqPrev_q <= 8'h00;
      intReq_q  <= 1'b0;
    end else begin
      busAck_q  <= busReq & ~busAck_q;
      irqPrev_q <= irqIn;
      intReq_q  <= reqWins & ready;
      if (busReq && !busAck_q) begin
        rdData_q  <= rdData_d;
        pollHit_q <= reqWins;
        pollLvl_q <= reqLvl;
      end
    end
  end

  // Acknowledge sequence: first cycle freezes the winner and drives
  // nothing, second cycle presents the registered vector
  always @(posedge core_clk) begin
    if (srst) begin
      ackPhase_q <= 1'b0;
      ackLevel_q <= `PIC_SPURIOUS_LVL;
      vecData_q  <= 8'h00;
      vecValid_q <= 1'b0;
    end else begin
      vecValid_q <= 1'b0;
      if (ack1) begin
        ackPhase_q <= 1'b1;
        ackLevel_q <= reqWins ? reqLvl : `PIC_SPURIOUS_LVL;
      end else if (ack2) begin
        ackPhase_q <= 1'b0;
        vecData_q  <= {vecBase_q, ackLevel_q};
        vecValid_q <= 1'b1;
      end
    end
  end

  // Setup sequence and operation words
  always @(posedge core_clk) begin
    if (srst) begin
      irr_q       <= 8'h00;
      isr_q       <= 8'h00;
      imr_q       <= `PIC_RST_MASK;
      slaveMap_q  <= 8'h00;
      vecBase_q   <= 5'h00;
      lowPri_q    <= `PIC_RST_LOWPRI;
      trigLevel_q <= 1'b0;
      single_q    <= 1'b1;
      needW4_q    <= 1'b0;
      auto_end_of_interrupt_q      <= 1'b0;
      special_nesting_select_q      <= 1'b0;
      smm_q       <= 1'b0;
      autoRot_q   <= 1'b0;
      readIsr_q   <= 1'b0;
      poll_q      <= 1'b0;
      initSt_q    <= ST_READY;
    end else if (setup1) begin
      // A new setup restarts the controller in fully nested mode
      irr_q       <= 8'h00;
      isr_q       <= 8'h00;
      imr_q       <= `PIC_RST_MASK;
      lowPri_q    <= `PIC_RST_LOWPRI;
      trigLevel_q <= wd[`PIC_W1_TRIG_BIT];
      single_q    <= wd[`PIC_W1_SINGLE_BIT];
      needW4_q    <= wd[`PIC_W1_W4_BIT];
      auto_end_of_interrupt_q      <= 1'b0;
      special_nesting_select_q      <= 1'b0;
      smm_q       <= 1'b0;
      autoRot_q   <= 1'b0;
      readIsr_q   <= 1'b0;
      poll_q      <= 1'b0;
      initSt_q    <= ST_W2;
    end else begin
      irr_q    <= irr_d;
      isr_q    <= isr_d;
      lowPri_q <= lowPri_d;
      if (opWord2) begin
        if (wd[7:5] == `PIC_CMD_AROT_SET)
          autoRot_q <= 1'b1;
        else if (wd[7:5] == `PIC_CMD_AROT_CLR)
          autoRot_q <= 1'b0;
      end
      if (opWord3) begin
        if (wd[`PIC_W3_ESMM_BIT])
          smm_q <= wd[`PIC_W3_SMM_BIT];
        if (wd[`PIC_W3_RR_BIT])
          readIsr_q <= wd[`PIC_W3_RS_BIT];
      end
      // A new poll request outranks clearing the previous one
      if (opWord3 && wd[`PIC_W3_POLL_BIT])
        poll_q <= 1'b1;
      else if (rdEn)
        poll_q <= 1'b0;
      if (oddWr) begin
        case (initSt_q)
          ST_W2: begin
            vecBase_q <= wd[7:3];
            if (!single_q)
              initSt_q <= ST_W3;
            else if (needW4_q)
              initSt_q <= ST_W4;
            else
              initSt_q <= ST_READY;
          end
          ST_W3: begin
            slaveMap_q <= wd;
            initSt_q   <= needW4_q ? ST_W4 : ST_READY;
          end
          ST_W4: begin
            special_nesting_select_q   <= wd[`PIC_W4_SPECIAL_NESTING_SELECT_BIT];
            auto_end_of_interrupt_q   <= wd[`PIC_W4_AUTO_END_OF_INTERRUPT_BIT];
            initSt_q <= ST_READY;
          end
          ST_READY: begin
            imr_q <= wd;
          end
          default: begin
            initSt_q <= ST_READY;
          end
        endcase
      end
    end
  end

endmodule

// [bench/pic_ctrl_monitor.sv]
// Checker for bus, vector and poll-read timing of the controller.
// Assumes it is bound to every pic_ctrl instance.
`timescale 1ns/100ps
module pic_ctrl_monitor (
  input wire        core_clk,
  input wire        srst,
  input wire [1:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        ackStrobe,
  input wire [7:0]  vecData,
  input wire        vecValid
);
  logic ackOdd_q;
  logic pollArm_q;
  wire  rdAcc = avs_read && !avs_waitrequest;
  wire  wrAcc = avs_write && !avs_waitrequest;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  // Pairs strobes the same way the host does: odd pulse opens a sequence
  always @(posedge core_clk) begin
    if (srst) begin
      ackOdd_q  <= 1'b0;
      pollArm_q <= 1'b0;
    end else begin
      if (ackStrobe)
        ackOdd_q <= !ackOdd_q;
      if (wrAcc && avs_address == 2'h0 && avs_writedata[4:2] == 3'h3)
        pollArm_q <= 1'b1;
      else if (rdAcc)
        pollArm_q <= 1'b0;
    end
  end
  a_wait_first: assert property ($rose(avs_read || avs_write)
    |-> avs_waitrequest) else $error("no wait on first cycle");
  a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("wait longer than one cycle");
  a_rd_high_zero: assert property (rdAcc |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (rdAcc && avs_address[1]
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_vec_single: assert property (vecValid |=> !vecValid)
    else $error("vector valid too long");
  a_first_quiet: assert property (ackStrobe && !ackOdd_q |=> !vecValid)
    else $error("vector on first cycle");
  a_second_vec: assert property (ackStrobe && ackOdd_q |=> vecValid)
    else $error("no vector after second cycle");
  a_vec_hold: assert property (!vecValid |-> $stable(vecData))
    else $error("vector changed outside sequence");
  a_poll_zeros: assert property (rdAcc && pollArm_q
    |-> avs_readdata[6:3] == 4'h0) else $error("poll bits 6:3 set");
  c_vector: cover property (vecValid);
  c_poll_read: cover property (rdAcc && pollArm_q);
  c_odd_read: cover property (rdAcc && avs_address == 2'h1);
endmodule
bind pic_ctrl pic_ctrl_monitor mon (.core_clk(core_clk), .srst(srst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .ackStrobe(ackStrobe),
  .vecData(vecData), .vecValid(vecValid));

// [bench/pic_host_model.sv]
// Host side: runs two-cycle acknowledge sequences on request.
// Assumes go is a one-cycle pulse; gap sets idle cycles between pulses.
`timescale 1ns/100ps
module pic_host_model (
  input  wire       core_clk,
  input  wire       srst,
  input  wire       go,
  input  wire [3:0] gap,
  output logic      ackStrobe,
  output logic      busy
);
  logic [4:0] cnt_q;
  always @(posedge core_clk) begin
    ackStrobe <= 1'b0;
    if (srst) begin
      busy  <= 1'b0;
      cnt_q <= 5'h00;
    end else if (!busy && go) begin
      busy      <= 1'b1;
      ackStrobe <= 1'b1;
      cnt_q     <= {1'b0, gap} + 5'h01;
    end else if (busy && cnt_q == 5'h01) begin
      // Second pulse always closes the sequence, even with gap zero
      busy      <= 1'b0;
      ackStrobe <= 1'b1;
    end else if (busy) begin
      cnt_q <= cnt_q - 5'h01;
    end
  end
endmodule

// [bench/test_priority_interrupt_controller.sv]
// Self-checking bench for the priority interrupt controller.
// Assumes pic_ctrl, its checker and the host model are compiled first.
`timescale 1ns/100ps
`define CHK(n, e, a) begin checksDone++; if ((a) !== (e)) begin \
  miscompares++; $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module test_priority_interrupt_controller;
  logic        coreClk = 0, srst = 1, rd = 0, wr = 0, go = 0;
  logic [1:0]  addr = 0;
  logic [31:0] wdat = 0, seed = 6231, r;
  logic [3:0]  be = 4'hF, gap = 0;
  logic [7:0]  irq = 0, got, v, slv;
  wire  [31:0] rdat;
  wire  [7:0]  vecData;
  wire         waitReq, intReq, vecValid, ackStrobe, busy;
  int          miscompares = 0, checksDone = 0, i;
  pic_ctrl dut (.core_clk(coreClk), .srst(srst), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(waitReq),
    .irqIn(irq), .ackStrobe(ackStrobe), .intReq(intReq),
    .vecData(vecData), .vecValid(vecValid));
  pic_host_model host (.core_clk(coreClk), .srst(srst), .go(go),
    .gap(gap), .ackStrobe(ackStrobe), .busy(busy));
  initial forever #20 coreClk = !coreClk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Highest requester when low names the lowest level
  function automatic logic [7:0] pick(logic [7:0] q, logic [2:0] low);
    logic [2:0] l;
    for (int k = 1; k <= 8; k++) begin
      l = low + k[2:0];
      if (q[l]) return {5'b10000, l};
    end
    return 8'h00;
  endfunction
  task automatic bus(input logic w, input logic [1:0] a, input [7:0] d);
    int n;
    n = 0;
    @(posedge coreClk);
    addr <= a;
    wdat <= {24'h0, d};
    rd <= !w;
    wr <= w;
    // Hold the request until waitrequest is seen low at a rising edge
    do begin @(posedge coreClk); n++; end
    while (waitReq !== 1'b0 && n < 50);
    got = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) miscompares++;
  endtask
  task automatic rdChk(input logic [1:0] a, input [7:0] e);
    bus(0, a, 8'h00);
    `CHK("readback", e, got);
  endtask
  task automatic ackChk(input [3:0] g, input [7:0] e);
    int n;
    n = 0;
    @(posedge coreClk);
    gap <= g;
    go <= 1'b1;
    @(posedge coreClk);
    go <= 1'b0;
    do begin @(negedge coreClk); n++; end
    while (vecValid !== 1'b1 && n < 40);
    if (n >= 40) miscompares++;
    `CHK("vector", e, vecData);
  endtask
  // Slave kept in default priority: its lowest set bit is its top level
  task automatic svcEnd;
    slv = slv & (slv - 8'h01);
    if (slv == 8'h00)
      bus(1, 2'h0, 8'h20);
  endtask
  // Request must rise again after a low cycle to be latched in edge mode
  task automatic pollChk(input [7:0] q, input [7:0] e);
    @(posedge coreClk);
    irq <= 8'h00;
    @(posedge coreClk);
    irq <= q;
    bus(1, 2'h0, 8'h0C);
    bus(0, 2'h1, 8'h00);
    `CHK("poll", e, got);
  endtask
  task automatic init(input [7:0] w4);
    bus(1, 2'h0, 8'h13);
    bus(1, 2'h1, 8'h40);
    bus(1, 2'h1, w4);
  endtask
  task automatic completeRun;
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge coreClk);
    miscompares++;
    completeRun;
  end
  initial begin
    repeat (6) @(posedge coreClk);
    srst <= 1'b0;
    init(8'h00);
    for (i = 0; i < 4; i++) begin
      v = xs();
      bus(1, 2'h1, v);
      rdChk(2'h1, v);
    end
    be <= 4'h0;
    bus(1, 2'h1, ~v);
    be <= 4'hF;
    rdChk(2'h1, v);
    rdChk(2'h2, 8'h00);
    bus(1, 2'h1, 8'h00);
    $display("mask test done");
    bus(1, 2'h0, 8'h0A);
    irq <= 8'h24;
    rdChk(2'h0, 8'h24);
    ackChk(4'h0, 8'h42);
    bus(1, 2'h0, 8'h0B);
    rdChk(2'h0, 8'h04);
    `CHK("intReq", 1'b0, intReq);
    irq <= 8'h25;
    repeat (4) @(posedge coreClk);
    `CHK("intReq", 1'b1, intReq);
    ackChk(4'h3, 8'h40);
    bus(1, 2'h0, 8'h20);
    rdChk(2'h0, 8'h04);
    bus(1, 2'h0, 8'h62);
    rdChk(2'h0, 8'h00);
    ackChk(4'h1, 8'h45);
    bus(1, 2'h0, 8'h65);
    bus(1, 2'h0, 8'h0A);
    rdChk(2'h0, 8'h00);
    irq <= 8'h00;
    ackChk(4'h2, 8'h47);
    bus(1, 2'h0, 8'h0B);
    rdChk(2'h0, 8'h00);
    $display("acknowledge test done");
    for (i = 0; i < 4; i++) begin
      r = xs();
      v = r[15:8] | 8'h01;
      bus(1, 2'h0, {5'b11000, r[2:0]});
      pollChk(v, pick(v, r[2:0]));
      bus(1, 2'h0, {5'b01100, got[2:0]});
    end
    bus(1, 2'h0, 8'h40);
    bus(1, 2'h0, 8'h00);
    $display("priority test done");
    @(posedge coreClk);
    irq <= 8'h00;
    init(8'h02);
    pollChk(8'h09, 8'h80);
    bus(1, 2'h0, 8'h60);
    bus(1, 2'h0, 8'h80);
    ackChk(4'h0, 8'h43);
    bus(1, 2'h0, 8'h0B);
    rdChk(2'h0, 8'h00);
    pollChk(8'h14, 8'h84);
    bus(1, 2'h0, 8'hE4);
    rdChk(2'h0, 8'h00);
    pollChk(8'h24, 8'h85);
    bus(1, 2'h0, 8'hA0);
    pollChk(8'h0A, 8'h81);
    $display("auto end test done");
    irq <= 8'h00;
    bus(1, 2'h0, 8'h19);
    bus(1, 2'h1, 8'h40);
    bus(1, 2'h1, 8'h04);
    bus(1, 2'h1, 8'h10);
    irq <= 8'h04;
    rdChk(2'h0, 8'h04);
    ackChk(4'h1, 8'h42);
    `CHK("intReq", 1'b1, intReq);
    slv = 8'h03;
    ackChk(4'h0, 8'h42);
    svcEnd;
    bus(1, 2'h0, 8'h0B);
    rdChk(2'h0, 8'h04);
    svcEnd;
    rdChk(2'h0, 8'h00);
    irq <= 8'h08;
    ackChk(4'h0, 8'h43);
    bus(1, 2'h1, 8'h08);
    bus(1, 2'h0, 8'h68);
    irq <= 8'h28;
    repeat (4) @(posedge coreClk);
    `CHK("intReq", 1'b1, intReq);
    bus(1, 2'h0, 8'h20);
    rdChk(2'h0, 8'h08);
    ackChk(4'h2, 8'h45);
    bus(1, 2'h0, 8'h20);
    rdChk(2'h0, 8'h08);
    irq <= 8'h00;
    bus(1, 2'h0, 8'h11);
    bus(1, 2'h1, 8'h40);
    bus(1, 2'h1, 8'h04);
    bus(1, 2'h1, 8'h02);
    irq <= 8'h02;
    ackChk(4'h0, 8'h41);
    bus(1, 2'h0, 8'h0B);
    rdChk(2'h0, 8'h00);
    $display("nesting test done");
    completeRun;
  end
endmodule
